// ===== hdl/acr_defines.vh
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH
// register word addresses (one register per bus word)
`define ACR_ADDR_CTRL0 4'h0
`define ACR_ADDR_CTRL1 4'h1
`define ACR_ADDR_TRIG 4'h2
`define ACR_ADDR_RESH 4'h3
`define ACR_ADDR_RESL 4'h4
`define ACR_ADDR_STAT 4'h5
// control 0 fields
`define ACR_C0_ON 0
`define ACR_C0_GO 1
`define ACR_C0_CHS_LSB 2
`define ACR_CHS_FVR2 6'h3F
// control 1 fields
`define ACR_C1_FMT 7
`define ACR_C1_CCS_LSB 4
`define ACR_C1_PREF_LSB 0
`define ACR_C1_MASK 8'hF3
`define ACR_PREF_VDD 2'h0
`define ACR_PREF_RSVD 2'h1
`define ACR_PREF_EXT 2'h2
`define ACR_PREF_FVR 2'h3
`define ACR_TRIG_MASK 8'h0F
// reset values
`define ACR_RST_CTRL0 8'h00
`define ACR_RST_CTRL1 8'h00
`define ACR_RST_TRIG 8'h00
// conversion clock codes
`define ACR_CCS_RC0 3'h3
`define ACR_CCS_RC1 3'h7
// conversion timing: bits per result
`define ACR_NBITS 4'hA
`endif

// ===== hdl/acr_sar.v
`timescale 1ns/1ps
`default_nettype none
`include "acr_defines.vh"
module acr_sar (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // control
  input wire start,
  input wire abort,
  input wire [2:0] clk_sel,
  input wire rc_tick,
  // analog core comparator decision
  input wire cmp_in,
  // status
  output reg busy_r,
  output reg done_r,
  output reg [9:0] result_r
);
  reg [5:0] div_r;
  reg [3:0] bit_r;
  reg [9:0] sar_r;
  reg tick;
  reg [9:0] part;
  integer i;
  // ------------------------------
  // conversion clock selection
  // ------------------------------
  always @* begin
    tick = 1'b0;
    part = sar_r;
    if (clk_sel == `ACR_CCS_RC0 || clk_sel == `ACR_CCS_RC1) begin
      tick = rc_tick;
    end else begin
      case (clk_sel)
        3'h0: tick = (div_r[0] == 1'b1);
        3'h1: tick = (div_r[2:0] == 3'h7);
        3'h2: tick = (div_r[4:0] == 5'h1F);
        3'h4: tick = (div_r[1:0] == 2'h3);
        3'h5: tick = (div_r[3:0] == 4'hF);
        default: tick = (div_r == 6'h3F);
      endcase
    end
    // unconverted bits copy the last converted bit (one above bit_r)
    for (i = 0; i < 10; i = i + 1) begin
      if (bit_r < 4'h9 && i <= bit_r) begin
        part[i] = sar_r[bit_r + 4'h1];
      end
    end
  end
  // ------------------------------
  // successive approximation
  // ------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 6'h00;
      bit_r <= 4'h0;
      sar_r <= 10'h000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      result_r <= 10'h000;
    end else begin
      div_r <= div_r + 6'h01;
      done_r <= 1'b0;
      if (start && !busy_r) begin
        busy_r <= 1'b1;
        bit_r <= `ACR_NBITS - 4'h1;
        sar_r <= 10'h000;
        div_r <= 6'h00;
      end else if (busy_r && abort) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
        result_r <= (bit_r == 4'h9) ? 10'h000 : part;
      end else if (busy_r && tick) begin
        sar_r[bit_r] <= cmp_in;
        if (bit_r == 4'h0) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          result_r <= {sar_r[9:1], cmp_in};
        end else begin
          bit_r <= bit_r - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/acr_top.v
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "acr_defines.vh"
//
// Contract
// - 6-bit channel select in control 0 bits 7:2; all ones picks fixed reference buffer 2.
// - positive reference code: 11 fixed ref, 10 external pin, 00 supply, 01 reserved.
// - left justified: result 9:2 fill the high result register.
// - left justified: result 1:0 in low register bits 7:6, rest zero.
// - right justified: result 9:8 in high register bits 1:0, upper six zero.
// - right justified: result 7:0 fill the low result register.
// - trigger sources act on rising edges only.
// - trigger register bits 7:4 read zero and hold no state.
// - converter stays off until enable bit set; writing go starts a conversion only if an earlier write set enable.
// - on completion clear go, set done flag, load result registers.
// - clearing go early stops conversion and loads partial result, bits copied.
// - selected trigger rising edge sets go in hardware.
module acr_top (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // trigger sources, one per code 1 to 15; code 0 selects none
  input wire [15:0] trig_src,
  // analog core
  input wire cmp_in,
  input wire rc_tick,
  output reg core_on_r,
  output reg [5:0] channel_select_r,
  output reg [1:0] pos_ref_sel_r,
  output reg conv_busy_r,
  // done flag
  output reg conversion_done_flag_r
);
  reg [7:0] ctrl0_r;
  reg [7:0] ctrl1_r;
  reg [3:0] trig_sel_r;
  reg [7:0] res_hi_r;
  reg [7:0] res_lo_r;
  reg [15:0] trig_prev_r;
  reg ack_r;
  reg start;
  reg abort;
  reg trig_edge;
  reg [7:0] rd_byte;
  reg wr_go;
  wire busy;
  wire done;
  wire [9:0] result;
  wire access;
  wire commit;
  wire fmt_right;
  // ------------------------------
  // conversion engine
  // ------------------------------
  acr_sar u_sar (
    .clk(clk),
    .rst_b(rst_b),
    .start(start),
    .abort(abort),
    .clk_sel(ctrl1_r[`ACR_C1_CCS_LSB+2:`ACR_C1_CCS_LSB]),
    .rc_tick(rc_tick),
    .cmp_in(cmp_in),
    .busy_r(busy),
    .done_r(done),
    .result_r(result)
  );
  assign access = (avs_read || avs_write) && !ack_r;
  // a write lands only at the edge where waitrequest is seen low
  assign commit = avs_write && !avs_waitrequest;
  assign fmt_right = ctrl1_r[`ACR_C1_FMT];
  // ------------------------------
  // triggers and start control
  // ------------------------------
  always @* begin
    trig_edge = 1'b0;
    if (trig_sel_r != 4'h0) begin
      trig_edge = trig_src[trig_sel_r] && !trig_prev_r[trig_sel_r];
    end
    wr_go = commit && avs_address == `ACR_ADDR_CTRL0 &&
      avs_writedata[`ACR_C0_GO] && avs_writedata[`ACR_C0_ON] && ctrl0_r[`ACR_C0_ON];
    start = (wr_go || trig_edge) && ctrl0_r[`ACR_C0_ON] && !busy;
    abort = busy && (!ctrl0_r[`ACR_C0_GO] || !ctrl0_r[`ACR_C0_ON]);
  end
  // ------------------------------
  // read mux
  // ------------------------------
  always @* begin
    rd_byte = 8'h00;
    if (avs_address == `ACR_ADDR_CTRL0) begin
      rd_byte = ctrl0_r;
    end else if (avs_address == `ACR_ADDR_CTRL1) begin
      rd_byte = ctrl1_r;
    end else if (avs_address == `ACR_ADDR_TRIG) begin
      rd_byte = {4'h0, trig_sel_r};
    end else if (avs_address == `ACR_ADDR_RESH) begin
      rd_byte = res_hi_r;
    end else if (avs_address == `ACR_ADDR_RESL) begin
      rd_byte = res_lo_r;
    end else if (avs_address == `ACR_ADDR_STAT) begin
      rd_byte = {6'h00, busy, conversion_done_flag_r};
    end
  end
  // ------------------------------
  // registers and bus answer
  // ------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl0_r <= `ACR_RST_CTRL0;
      ctrl1_r <= `ACR_RST_CTRL1;
      trig_sel_r <= 4'h0;
      res_hi_r <= 8'h00;
      res_lo_r <= 8'h00;
      trig_prev_r <= 16'h0000;
      ack_r <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      core_on_r <= 1'b0;
      channel_select_r <= 6'h00;
      pos_ref_sel_r <= 2'h0;
      conv_busy_r <= 1'b0;
      conversion_done_flag_r <= 1'b0;
    end else begin
      trig_prev_r <= trig_src;
      ack_r <= access;
      avs_waitrequest <= !access;
      if (access && avs_read) begin
        avs_readdata <= {24'h000000, rd_byte};
      end
      if (commit) begin
        if (avs_address == `ACR_ADDR_CTRL0) begin
          ctrl0_r <= avs_writedata[7:0];
          if (!avs_writedata[`ACR_C0_ON] || !ctrl0_r[`ACR_C0_ON]) begin
            ctrl0_r[`ACR_C0_GO] <= 1'b0;
          end
        end else if (avs_address == `ACR_ADDR_CTRL1) begin
          ctrl1_r <= avs_writedata[7:0] & `ACR_C1_MASK;
        end else if (avs_address == `ACR_ADDR_TRIG) begin
          trig_sel_r <= avs_writedata[3:0];
        end else if (avs_address == `ACR_ADDR_RESH) begin
          res_hi_r <= avs_writedata[7:0];
        end else if (avs_address == `ACR_ADDR_RESL) begin
          res_lo_r <= avs_writedata[7:0];
        end else if (avs_address == `ACR_ADDR_STAT) begin
          if (avs_writedata[0]) begin
            conversion_done_flag_r <= 1'b0;
          end
        end
      end
      if (trig_edge && ctrl0_r[`ACR_C0_ON] && !busy) begin
        ctrl0_r[`ACR_C0_GO] <= 1'b1;
      end
      if (done) begin
        ctrl0_r[`ACR_C0_GO] <= 1'b0;
        conversion_done_flag_r <= 1'b1;
        if (fmt_right) begin
          res_hi_r <= {6'h00, result[9:8]};
          res_lo_r <= result[7:0];
        end else begin
          res_hi_r <= result[9:2];
          res_lo_r <= {result[1:0], 6'h00};
        end
      end
      core_on_r <= ctrl0_r[`ACR_C0_ON];
      channel_select_r <= ctrl0_r[7:`ACR_C0_CHS_LSB];
      pos_ref_sel_r <= ctrl1_r[`ACR_C1_PREF_LSB+1:`ACR_C1_PREF_LSB];
      conv_busy_r <= busy;
    end
  end
endmodule
`default_nettype wire

// ===== verif/acr_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module acr_top_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // core side
  input wire logic [15:0] trig_src,
  input wire logic core_on_r,
  input wire logic [5:0] channel_select_r,
  input wire logic [1:0] pos_ref_sel_r,
  input wire logic conv_busy_r,
  input wire logic conversion_done_flag_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] trig_q;
  logic rise_q;
  // trigger rising edges seen one edge late
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_q <= 16'h0000;
      rise_q <= 1'h0;
    end else begin
      trig_q <= trig_src;
      rise_q <= |(trig_src & ~trig_q);
    end
  end
  property p_bus; (avs_read || avs_write) |-> ##[0:2] !avs_waitrequest; endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");
  property p_ws; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_ws: assert property (p_ws) else $error("answer held too long");
  property p_chs; avs_write && !avs_waitrequest && avs_address == 4'h0 |-> ##2
    channel_select_r == $past(avs_writedata[7:2], 2) &&
    core_on_r == $past(avs_writedata[0], 2); endproperty
  a_chs: assert property (p_chs) else $error("channel or enable wrong");
  property p_pref; avs_write && !avs_waitrequest && avs_address == 4'h1 |-> ##2
    pos_ref_sel_r == $past(avs_writedata[1:0], 2); endproperty
  a_pref: assert property (p_pref) else $error("reference select wrong");
  property p_trig; avs_read && !avs_waitrequest && avs_address == 4'h2 |->
    avs_readdata[31:4] == 28'h0000000; endproperty
  a_trig: assert property (p_trig) else $error("trigger upper bits set");
  property p_start; $rose(conv_busy_r) |-> core_on_r; endproperty
  a_start: assert property (p_start) else $error("conversion while off");
  property p_cause; $rose(conv_busy_r) |->
    $past(avs_write) || $past(avs_write, 2) || rise_q || $past(rise_q); endproperty
  a_cause: assert property (p_cause) else $error("start without cause");
  property p_done; $rose(conversion_done_flag_r) |-> !conv_busy_r && $past(conv_busy_r, 2);
  endproperty
  a_done: assert property (p_done) else $error("done flag without conversion");
  property p_off; $fell(core_on_r) |-> ##[0:2] !conv_busy_r; endproperty
  a_off: assert property (p_off) else $error("conversion kept after disable");
  cover property ($rose(conversion_done_flag_r));
  cover property (rise_q ##[1:3] $rose(conv_busy_r));
  cover property ($fell(conv_busy_r) && !conversion_done_flag_r);
endmodule
bind acr_top acr_top_props u_acr_top_props (.clk(clk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .trig_src(trig_src), .core_on_r(core_on_r),
  .channel_select_r(channel_select_r), .pos_ref_sel_r(pos_ref_sel_r),
  .conv_busy_r(conv_busy_r), .conversion_done_flag_r(conversion_done_flag_r));
`default_nettype wire

// ===== verif/acr_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module acr_top_test;
  logic clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, cmp_in = 0, rc_tick = 0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, core_on_r, conv_busy_r, conversion_done_flag_r;
  logic [15:0] trig_src = 16'h0000, e;
  logic [5:0] channel_select_r;
  logic [1:0] pos_ref_sel_r;
  logic [7:0] q, d;
  integer err_total = 0, checks_done = 0, cyc = 0, seed = 32'hf53e, i, n;
  always #5 clk = ~clk;
  always @(posedge clk) rc_tick <= 1'($random(seed));
  acr_top u_acr_top (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trig_src(trig_src),
    .cmp_in(cmp_in), .rc_tick(rc_tick), .core_on_r(core_on_r),
    .channel_select_r(channel_select_r), .pos_ref_sel_r(pos_ref_sel_r),
    .conv_busy_r(conv_busy_r), .conversion_done_flag_r(conversion_done_flag_r));
  function [15:0] fmtd(input [9:0] r, input f);
    fmtd = f ? {6'h00, r} : {r, 6'h00};
  endfunction
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input [7:0] s, input [7:0] x);
    checks_done = checks_done + 1;
    if (s !== x) begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  task bus(input w, input [3:0] a, input [7:0] dw, output [7:0] r);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, dw};
    @(posedge clk);
    while (avs_waitrequest !== 1'h0) begin
      @(posedge clk);
    end
    r = avs_readdata[7:0];
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task conv(input c, input [7:0] c1);
    bus(1, 4'h1, c1, q);
    cmp_in <= c;
    bus(1, 4'h0, 8'h01, q);
    bus(1, 4'h0, 8'h03, q);
    n = 0;
    do begin
      bus(0, 4'h5, 8'h00, q);
      n = n + 1;
    end while (q[0] !== 1'h1 && n < 300);
    e = fmtd({10{c}}, c1[7]);
    chk("status", q, 8'h01);
    bus(0, 4'h0, 8'h00, q);
    chk("go", q, 8'h01);
    bus(0, 4'h3, 8'h00, q);
    chk("res_hi", q, e[15:8]);
    bus(0, 4'h4, 8'h00, q);
    chk("res_lo", q, e[7:0]);
    bus(1, 4'h5, 8'h01, q);
    bus(0, 4'h5, 8'h00, q);
    chk("flag_clear", q, 8'h00);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      complete_run;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    for (i = 0; i < 8; i++) begin
      bus(0, i[3:0], 8'h00, q);
      if (i < 3 || i > 5) chk("reset_or_unmapped", q, 8'h00);
    end
    for (i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'hFC : 8'($random(seed)) & 8'hFD;
      bus(1, 4'h0, d, q);
      bus(0, 4'h0, 8'h00, q);
      chk("chan", {2'h0, channel_select_r}, {2'h0, d[7:2]});
      chk("ctrl0", q, d);
      d = {8'($random(seed)) & 8'hFC} | {6'h00, i[1:0]};
      bus(1, 4'h1, d, q);
      bus(0, 4'h1, 8'h00, q);
      chk("pref", {6'h00, pos_ref_sel_r}, {6'h00, i[1:0]});
      chk("ctrl1", q, d & 8'hF3);
      bus(1, 4'h2, 8'($random(seed)), q);
      bus(0, 4'h2, 8'h00, q);
      chk("trig_hi", q & 8'hF0, 8'h00);
    end
    bus(1, 4'h2, 8'h00, q);
    bus(1, 4'h0, 8'h00, q);
    bus(1, 4'h0, 8'h03, q);
    bus(0, 4'h5, 8'h00, q);
    chk("go_with_enable", q, 8'h00);
    $display("register tests done");
    conv(1, 8'h00);
    conv(1, 8'h80);
    conv(0, 8'hC1);
    conv(1, 8'h33);
    $display("conversion tests done");
    bus(1, 4'h1, 8'h60, q);
    cmp_in <= 1'h1;
    bus(1, 4'h0, 8'h03, q);
    repeat (200) @(posedge clk);
    bus(1, 4'h0, 8'h01, q);
    bus(0, 4'h5, 8'h00, q);
    chk("abort_busy", q & 8'h02, 8'h00);
    bus(0, 4'h3, 8'h00, q);
    chk("abort_hi", q, 8'hFF);
    $display("abort test done");
    bus(1, 4'h1, 8'h00, q);
    for (i = 1; i < 16; i++) begin
      bus(1, 4'h2, i[7:0], q);
      trig_src[i] <= 1'h1;
      n = 0;
      while (conv_busy_r !== 1'h1 && n < 8) begin
        @(negedge clk);
        n = n + 1;
      end
      chk("trig_start", {7'h00, conv_busy_r}, 8'h01);
      while (conv_busy_r !== 1'h0 && n < 200) begin
        @(negedge clk);
        n = n + 1;
      end
      bus(1, 4'h5, 8'h01, q);
      trig_src[i] <= 1'h0;
      repeat (6) @(posedge clk);
      chk("trig_fall", {7'h00, conv_busy_r}, 8'h00);
    end
    $display("trigger tests done");
    complete_run;
  end
endmodule
`default_nettype wire
